// ==== rtl/fbx_defs.vh ====
`ifndef FBX_DEFS_VH
`define FBX_DEFS_VH

// ----------------------------------------
// Bus variants and station addressing
// ----------------------------------------
`define FBX_BUS_PB 1'b0
`define FBX_BUS_PN 1'b1
`define FBX_ADDR_MIN 7'h01
`define FBX_ADDR_MAX 7'h7D

// ----------------------------------------
// Slave state codes
// ----------------------------------------
`define FBX_ST_INIT 3'h0
`define FBX_ST_WAIT 3'h2
`define FBX_ST_RUN 3'h4

// ----------------------------------------
// Configuration results
// ----------------------------------------
`define FBX_CFG_OK 2'h0
`define FBX_CFG_ERR 2'h3

// ----------------------------------------
// Timing: configuration busy time (2 to 3 s)
// ----------------------------------------
`define FBX_CFG_TIME_MS 2000
`define FBX_CLK_MHZ 50

// ----------------------------------------
// Area geometry
// ----------------------------------------
`define FBX_WORD_W 32
`define FBX_AREA_MAX 10'h140
`define FBX_PB_AREA_MAX 10'h03D

`endif

// ==== rtl/fbx_fifo.v ====
`timescale 1ns/100ps
// Synchronous FIFO with valid/ready on both sides
module fbx_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // Honest full and empty from the fill count
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage, no reset needed on the array
  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and count
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ==== rtl/fbx_ram.v ====
`timescale 1ns/100ps
// Simple dual-port RAM, registered read data
module fbx_ram #(
  parameter WIDTH = 32,
  parameter DEPTH = 512,
  parameter AW = 9
) (
  input wire clock,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Write and registered read
  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ==== rtl/fbx_slave.v ====
// Behaviour
// - Station address lies in 1..125; node answers master only at that address.
// - Profibus areas accept only 1,2,4,8,16,32 or 61 double words.
// - Configuration is slow, about two to three seconds; host runs it low priority.
// - Configuration completes before any exchange; exchange on unconfigured node refused.
// - Each exchange sends count outgoing words from host to the bus; code sends none while the node is not running.
// - Each exchange returns latest received words to host, same count; code returns none while the node is not running.
// - Profibus exchange reports state 0 init, 2 waiting, 4 running.
// - One transfer count governs both directions of an exchange.
// - Incoming words beyond configured input size are undefined.
// - Every element is one 32-bit double word.
// - Profinet areas accept 1,2,4,...,128,196,256 or 320 double words.
// - Profinet configuration returns 0 on success, -1 on bad size.
// - Profinet exchange reports state 0 init, 2 waiting, 4 running.
// - Profinet exchange delivers received bus data into host buffer; code delivers none while the node is not running.
`timescale 1ns/100ps
`include "fbx_defs.vh"
module fbx_slave #(
  parameter WORD_W = `FBX_WORD_W,
  parameter CFG_TIME_MS = `FBX_CFG_TIME_MS,
  parameter CFG_CYCLES = CFG_TIME_MS * `FBX_CLK_MHZ * 1000,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire clock,
  input wire sys_rst,
  input wire cfg_start,
  input wire cfg_bus_type,
  input wire [6:0] cfg_station_addr,
  input wire [9:0] cfg_in_size,
  input wire [9:0] cfg_out_size,
  output reg cfg_busy,
  output reg cfg_done,
  output reg [1:0] cfg_result,
  input wire xchg_start,
  input wire [9:0] transfer_word_count,
  output wire out_ready,
  input wire out_valid,
  input wire [WORD_W-1:0] outgoing_buffer,
  output reg in_valid,
  output reg [WORD_W-1:0] incoming_buffer,
  output reg in_defined,
  output reg xchg_done,
  output reg xchg_refused,
  output reg [2:0] xchg_state,
  input wire bus_running_async,
  input wire bus_started_async,
  input wire bus_rx_valid,
  input wire [6:0] bus_rx_addr,
  input wire [9:0] bus_rx_index,
  input wire [WORD_W-1:0] bus_rx_data,
  output wire bus_tx_valid,
  input wire bus_tx_ready,
  output wire [WORD_W-1:0] bus_tx_data,
  output reg [6:0] node_addr
);
  // ----------------------------------------
  // States, one-hot
  // ----------------------------------------
  localparam S_IDLE = 4'b0001;
  localparam S_CFG = 4'b0010;
  localparam S_OUT = 4'b0100;
  localparam S_IN = 4'b1000;

  reg [3:0] state;
  reg [3:0] next_state;
  reg configured;
  reg cfg_bus;
  reg [9:0] in_size;
  reg [31:0] cfg_cnt;
  reg [9:0] words_left;
  reg [9:0] rd_idx;
  reg [9:0] xchg_count;
  reg rd_pending;
  reg run_meta;
  reg run_sync;
  reg start_meta;
  reg start_sync;
  wire [WORD_W-1:0] ram_rd;
  wire fifo_in_ready;
  wire rx_write;

  // ----------------------------------------
  // Size checks
  // ----------------------------------------
  // Profibus size table; note 61, not 64
  function pb_size_ok;
    input [9:0] s;
    begin
      case (s)
        10'h001, 10'h002, 10'h004, 10'h008, 10'h010, 10'h020, `FBX_PB_AREA_MAX: pb_size_ok = 1'b1;
        default: pb_size_ok = 1'b0;
      endcase
    end
  endfunction

  // Profinet size table, 196 is irregular but listed
  function pn_size_ok;
    input [9:0] s;
    begin
      case (s)
        10'h001, 10'h002, 10'h004, 10'h008, 10'h010, 10'h020, 10'h040, 10'h080,
        10'h0C4, 10'h100, `FBX_AREA_MAX: pn_size_ok = 1'b1;
        default: pn_size_ok = 1'b0;
      endcase
    end
  endfunction

  function size_ok;
    input bus;
    input [9:0] s;
    begin
      size_ok = (bus == `FBX_BUS_PN) ? pn_size_ok(s) : pb_size_ok(s);
    end
  endfunction

  wire addr_ok = (cfg_station_addr >= `FBX_ADDR_MIN) && (cfg_station_addr <= `FBX_ADDR_MAX);
  // Profinet has no station address in its setup
  wire cfg_ok = size_ok(cfg_bus_type, cfg_in_size) && size_ok(cfg_bus_type, cfg_out_size) &&
    ((cfg_bus_type == `FBX_BUS_PN) || addr_ok);
  wire count_ok = size_ok(cfg_bus, transfer_word_count);

  // ----------------------------------------
  // Bus status synchronisers
  // ----------------------------------------
  // Two flops each; only the second is read
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_meta <= 1'b0;
      run_sync <= 1'b0;
      start_meta <= 1'b0;
      start_sync <= 1'b0;
    end else begin
      run_meta <= bus_running_async;
      run_sync <= run_meta;
      start_meta <= bus_started_async;
      start_sync <= start_meta;
    end
  end

  // Slave state code from configuration and bus status
  function [2:0] state_code;
    input cfg_flag;
    input run_flag;
    input start_flag;
    begin
      if (!cfg_flag) begin
        state_code = `FBX_ST_INIT;
      end else if (run_flag) begin
        state_code = `FBX_ST_RUN;
      end else if (start_flag) begin
        // Started but no cyclic traffic yet, still waiting
        state_code = `FBX_ST_WAIT;
      end else begin
        state_code = `FBX_ST_WAIT;
      end
    end
  endfunction

  // Code reported with every exchange
  wire [2:0] slave_state = state_code(configured, run_sync, start_sync);
  wire running = (slave_state == `FBX_ST_RUN);

  // ----------------------------------------
  // Received image memory
  // ----------------------------------------
  // Profibus frames must carry our address; Profinet has none to match
  wire addr_hit = (cfg_bus == `FBX_BUS_PN) || (bus_rx_addr == node_addr);

  // Only hits while running update the image; words past the area are dropped
  assign rx_write = bus_rx_valid && running && addr_hit &&
    (bus_rx_index < in_size);

  fbx_ram #(
    .WIDTH(WORD_W),
    .DEPTH(512),
    .AW(9)
  ) u_ram (
    .clock(clock),
    .wr_en(rx_write),
    .wr_addr(bus_rx_index[8:0]),
    .wr_data(bus_rx_data),
    .rd_addr(rd_idx[8:0]),
    .rd_data(ram_rd)
  );

  // ----------------------------------------
  // Outgoing FIFO toward the bus
  // ----------------------------------------
  // Bus side stalls it; host sees back-pressure on out_ready
  wire fifo_push = (state == S_OUT) && out_valid && (words_left != 10'h000);
  assign out_ready = (state == S_OUT) && fifo_in_ready && (words_left != 10'h000);

  fbx_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(outgoing_buffer),
    .out_valid(bus_tx_valid),
    .out_ready(bus_tx_ready),
    .out_data(bus_tx_data)
  );

  // ----------------------------------------
  // Control state machine
  // ----------------------------------------
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (cfg_start) begin
          next_state = S_CFG;
        end else if (xchg_start && configured && count_ok) begin
          // Not running: skip the send, deliver nothing new
          next_state = running ? S_OUT : S_IDLE;
        end
      end
      S_CFG: begin
        if (!cfg_ok || (cfg_cnt == 32'h0000_0001)) begin
          next_state = S_IDLE;
        end
      end
      S_OUT: begin
        if ((words_left == 10'h001) && out_valid && fifo_in_ready) begin
          next_state = S_IN;
        end
      end
      S_IN: begin
        if ((words_left == 10'h000) && !rd_pending) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // Registered control and data path
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_IDLE;
      configured <= 1'b0;
      cfg_bus <= `FBX_BUS_PB;
      in_size <= 10'h000;
      node_addr <= 7'h00;
      cfg_cnt <= 32'h0000_0000;
      cfg_busy <= 1'b0;
      cfg_done <= 1'b0;
      cfg_result <= `FBX_CFG_OK;
      words_left <= 10'h000;
      rd_idx <= 10'h000;
      xchg_count <= 10'h000;
      rd_pending <= 1'b0;
      in_valid <= 1'b0;
      incoming_buffer <= {WORD_W{1'b0}};
      in_defined <= 1'b0;
      xchg_done <= 1'b0;
      xchg_refused <= 1'b0;
      xchg_state <= `FBX_ST_INIT;
    end else begin
      state <= next_state;
      cfg_done <= 1'b0;
      xchg_done <= 1'b0;
      xchg_refused <= 1'b0;
      in_valid <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cfg_start) begin
            // Reconfiguration drops the node back to init
            configured <= 1'b0;
            cfg_busy <= 1'b1;
            cfg_cnt <= CFG_CYCLES;
            cfg_bus <= cfg_bus_type;
          end else if (xchg_start) begin
            if (!configured || !count_ok) begin
              xchg_refused <= 1'b1;
              xchg_state <= slave_state;
            end else if (!running) begin
              xchg_done <= 1'b1;
              xchg_state <= slave_state;
            end else begin
              xchg_state <= slave_state;
              words_left <= transfer_word_count;
              xchg_count <= transfer_word_count;
            end
          end
        end
        S_CFG: begin
          cfg_cnt <= cfg_cnt - 32'h0000_0001;
          if (!cfg_ok) begin
            cfg_busy <= 1'b0;
            cfg_done <= 1'b1;
            cfg_result <= `FBX_CFG_ERR;
          end else if (cfg_cnt == 32'h0000_0001) begin
            // Input size and station address captured at the end; host holds them stable
            cfg_busy <= 1'b0;
            cfg_done <= 1'b1;
            cfg_result <= `FBX_CFG_OK;
            configured <= 1'b1;
            in_size <= cfg_in_size;
            node_addr <= cfg_station_addr;
          end
        end
        S_OUT: begin
          if (out_valid && fifo_in_ready) begin
            words_left <= words_left - 10'h001;
            if (words_left == 10'h001) begin
              words_left <= xchg_count;
              rd_idx <= 10'h000;
            end
          end
        end
        S_IN: begin
          // One read in flight; RAM data lag by a cycle
          rd_pending <= (words_left != 10'h000);
          if (words_left != 10'h000) begin
            rd_idx <= rd_idx + 10'h001;
            words_left <= words_left - 10'h001;
          end
          if (rd_pending) begin
            in_valid <= 1'b1;
            incoming_buffer <= ram_rd;
            in_defined <= ((rd_idx - 10'h001) < in_size);
          end
          if ((words_left == 10'h000) && !rd_pending) begin
            xchg_done <= 1'b1;
          end
        end
        default: begin
          cfg_busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ==== test/fbx_master_model.sv ====
`timescale 1ns/100ps
// ------
// Fieldbus master stand-in
// ------
module fbx_master_model (
  input wire clock,
  input wire run,
  input wire stall,
  input wire bus_tx_valid,
  input wire [31:0] bus_tx_data,
  output logic bus_running_async,
  output logic bus_started_async,
  output logic bus_tx_ready,
  output logic bus_rx_valid,
  output logic [6:0] bus_rx_addr,
  output logic [9:0] bus_rx_index,
  output logic [31:0] bus_rx_data
);
  logic [31:0] tx_seen[$];
  // Bus start and flow control follow the bench; stall gives a slow master
  assign bus_running_async = run;
  assign bus_started_async = run;
  assign bus_tx_ready = !stall;
  // Record each word the slave sends
  always @(posedge clock) begin
    if (bus_tx_valid && bus_tx_ready)
      tx_seen.push_back(bus_tx_data);
  end
  initial begin
    bus_rx_valid = 0;
    bus_rx_addr = 0;
    bus_rx_index = 0;
    bus_rx_data = 0;
  end
  // Image to one station, as projected; released lines show junk
  task send_image(input [6:0] a, input [9:0] n, input [31:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      #1;
      bus_rx_valid = 1;
      bus_rx_addr = a;
      bus_rx_index = i[9:0];
      bus_rx_data = base + i;
    end
    @(posedge clock);
    #1;
    bus_rx_valid = 0;
    bus_rx_addr = ~a;
    bus_rx_data = ~bus_rx_data;
  endtask
endmodule

// ==== test/fbx_slave_monitor.sv ====
`timescale 1ns/100ps
// ------
// Checker
// ------
module fbx_monitor (
  input wire clock,
  input wire sys_rst,
  input wire cfg_start,
  input wire cfg_bus_type,
  input wire [6:0] cfg_station_addr,
  input wire [9:0] cfg_in_size,
  input wire [9:0] cfg_out_size,
  input wire cfg_busy,
  input wire cfg_done,
  input wire [1:0] cfg_result,
  input wire xchg_start,
  input wire [9:0] transfer_word_count,
  input wire out_ready,
  input wire in_valid,
  input wire in_defined,
  input wire xchg_done,
  input wire [2:0] xchg_state,
  input wire bus_tx_valid,
  input wire bus_tx_ready,
  input wire [31:0] bus_tx_data
);
  reg [9:0] in_sz;
  reg [9:0] in_pend;
  reg [9:0] n_lat;
  reg [9:0] idx;
  // Area size of the last good setup, count and word index of the running operation
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      in_sz <= 10'h000;
      in_pend <= 10'h000;
      n_lat <= 10'h000;
      idx <= 10'h000;
    end else begin
      if (cfg_start && !cfg_busy)
        in_pend <= cfg_in_size;
      if (cfg_done && cfg_result == 2'h0)
        in_sz <= in_pend;
      if (xchg_start) begin
        n_lat <= transfer_word_count;
        idx <= 10'h000;
      end else if (in_valid)
        idx <= idx + 10'h001;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_bad_addr;
    cfg_start && !cfg_busy && !cfg_bus_type && cfg_station_addr == 7'h7E |-> ##2 cfg_done && cfg_result == 2'h3;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("bad address accepted");
  property p_bad_pb;
    cfg_start && !cfg_busy && !cfg_bus_type && cfg_out_size == 10'h040 |-> ##2 cfg_done && cfg_result == 2'h3;
  endproperty
  a_bad_pb: assert property (p_bad_pb) else $error("bad size accepted");
  property p_bad_pn;
    cfg_start && !cfg_busy && cfg_bus_type && cfg_in_size == 10'h0C5 |-> ##2 cfg_done && cfg_result == 2'h3;
  endproperty
  a_bad_pn: assert property (p_bad_pn) else $error("bad size accepted");
  property p_busy;
    cfg_busy |-> !out_ready && !in_valid && !xchg_done;
  endproperty
  a_busy: assert property (p_busy) else $error("exchange during setup");
  property p_tx_hold;
    bus_tx_valid && !bus_tx_ready |=> bus_tx_valid && $stable(bus_tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("send word dropped");
  property p_code;
    xchg_done |-> (xchg_state == 3'h0 || xchg_state == 3'h2 || xchg_state == 3'h4) ##1 !xchg_done;
  endproperty
  a_code: assert property (p_code) else $error("bad state code");
  property p_defined;
    in_valid |-> in_defined == (idx < in_sz);
  endproperty
  a_defined: assert property (p_defined) else $error("defined flag wrong");
  property p_count;
    xchg_done && xchg_state == 3'h4 |-> idx == n_lat;
  endproperty
  a_count: assert property (p_count) else $error("word count wrong");
endmodule

bind fbx_slave fbx_monitor mon (.*);

// ==== test/fbx_slave_tb.sv ====
`timescale 1ns/100ps
module fbx_slave_tb;
  logic clock, sys_rst, cfg_start, cfg_bus_type, cfg_busy, cfg_done, run, stall;
  logic xchg_start, out_ready, out_valid, in_valid, in_defined, xchg_done, xchg_refused;
  logic bus_running_async, bus_started_async, bus_rx_valid, bus_tx_valid, bus_tx_ready;
  logic [6:0] cfg_station_addr, bus_rx_addr, node_addr;
  logic [9:0] cfg_in_size, cfg_out_size, transfer_word_count, bus_rx_index;
  logic [1:0] cfg_result;
  logic [2:0] xchg_state;
  logic [31:0] outgoing_buffer, incoming_buffer, bus_rx_data, bus_tx_data;
  logic [31:0] in_q[$];
  logic def_q[$];
  int num_errors, cmp_count, cyc;

  // Short setup time keeps the run brief
  localparam int CFG_CYC = 10;
  fbx_slave #(.CFG_CYCLES(CFG_CYC)) uut (.*);
  fbx_master_model master (.*);

  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      close_out;
    end
  end
  // Collect words handed to the host
  always @(posedge clock) begin
    if (in_valid) begin
      in_q.push_back(incoming_buffer);
      def_q.push_back(in_defined);
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task close_out;
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task tick;
    @(posedge clock);
    #1;
  endtask
  task refuse(input [9:0] n);
    logic seen;
    seen = 0;
    transfer_word_count = n;
    xchg_start = 1;
    tick;
    xchg_start = 0;
    repeat (3) begin
      seen = seen | (xchg_refused === 1'b1);
      tick;
    end
    chk("refused", 1, seen);
  endtask
  task cfg(input bt, input [6:0] a, input [9:0] i, input [9:0] o, input [1:0] res, input int lat);
    int n;
    cfg_bus_type = bt;
    cfg_station_addr = a;
    cfg_in_size = i;
    cfg_out_size = o;
    cfg_start = 1;
    tick;
    cfg_start = 0;
    chk("cfg_busy", 1, cfg_busy);
    // Done shows after edge n and is sampled 1 ns after that same edge
    n = 1;
    while (cfg_done !== 1'b1) begin
      tick;
      n++;
    end
    chk("cfg_result", res, cfg_result);
    chk("cfg_time", lat, n);
  endtask
  task xchg(input [9:0] n, input [9:0] insz, input [2:0] st, input [31:0] base);
    in_q.delete();
    def_q.delete();
    master.tx_seen.delete();
    transfer_word_count = n;
    xchg_start = 1;
    tick;
    xchg_start = 0;
    // Host words, held until taken
    for (int k = 0; k < n && st == 3'h4; k++) begin
      outgoing_buffer = 32'hA0000000 + k;
      out_valid = 1;
      while (out_ready !== 1'b1)
        tick;
      tick;
    end
    out_valid = 0;
    while (xchg_done !== 1'b1)
      tick;
    chk("state", st, xchg_state);
    while (bus_tx_valid === 1'b1)
      tick;
    chk("in_count", (st == 3'h4) ? n : 0, in_q.size());
    chk("tx_count", (st == 3'h4) ? n : 0, master.tx_seen.size());
    for (int k = 0; k < in_q.size(); k++) begin
      chk("in_defined", k < insz, def_q[k]);
      if (k < insz)
        chk("in_word", base + k, in_q[k]);
    end
    for (int k = 0; k < master.tx_seen.size(); k++)
      chk("tx_word", 32'hA0000000 + k, master.tx_seen[k]);
  endtask

  initial begin
    {cfg_start, cfg_bus_type, xchg_start, out_valid, run, stall} = 6'h00;
    {cfg_station_addr, cfg_in_size, cfg_out_size, transfer_word_count} = 37'h0;
    outgoing_buffer = 0;
    sys_rst = 1;
    repeat (8) @(posedge clock);
    #1;
    sys_rst = 0;
    refuse(10'h010);
    cfg(1, 7'h00, 10'h0C5, 10'h001, 2'h3, 2);
    cfg(0, 7'h02, 10'h008, 10'h040, 2'h3, 2);
    cfg(0, 7'h7E, 10'h008, 10'h020, 2'h3, 2);
    cfg(0, 7'h02, 10'h008, 10'h020, 2'h0, CFG_CYC + 1);
    chk("node_addr", 7'h02, node_addr);
    xchg(10'h020, 10'h008, 3'h2, 32'h00000000);
    refuse(10'h003);
    run = 1;
    repeat (4) tick;
    master.send_image(7'h02, 10'h008, 32'hC0DE0000);
    master.send_image(7'h03, 10'h008, 32'h0BAD0000);
    // Stalled master fills the send buffer until the host is held off
    stall = 1;
    fork
      begin
        repeat (60) tick;
        stall = 0;
      end
    join_none
    xchg(10'h020, 10'h008, 3'h4, 32'hC0DE0000);
    cfg(1, 7'h00, 10'h0C4, 10'h140, 2'h0, CFG_CYC + 1);
    // Fresh pattern, so stale words from the earlier image cannot pass
    master.send_image(7'h05, 10'h0C4, 32'h5EED0000);
    xchg(10'h004, 10'h0C4, 3'h4, 32'h5EED0000);
    close_out;
  end
endmodule
